// ---- pkg/tcsel_pkg.sv ----
// Constants for the timer 0/1 clock select and prescaler block
package tcsel_pkg;
  localparam logic [7:0] TCSEL_CLK_CTRL_ADDR = 8'h8E;
  localparam logic [7:0] TCSEL_CLK_CTRL_RESET = 8'h00;
  localparam logic [7:0] TCSEL_CLK_CTRL_WMASK = 8'h1B;
  localparam int TCSEL_T1_SEL_BIT = 4;
  localparam int TCSEL_T0_SEL_BIT = 3;
  localparam int TCSEL_FIELD_LSB = 0;
  localparam int TCSEL_FIELD_W = 2;
  localparam logic [1:0] TCSEL_PRE_SYS12 = 2'h0;
  localparam logic [1:0] TCSEL_PRE_SYS4 = 2'h1;
  localparam logic [1:0] TCSEL_PRE_SYS48 = 2'h2;
  localparam logic [1:0] TCSEL_PRE_EXT8 = 2'h3;
  localparam int TCSEL_DIV_SYS12 = 12;
  localparam int TCSEL_DIV_SYS4 = 4;
  localparam int TCSEL_DIV_SYS48 = 48;
  localparam int TCSEL_DIV_EXT8 = 8;
  localparam int TCSEL_CNT_W = 6;
  localparam int TCSEL_SYNC_STAGES = 3;
endpackage

// ---- pkg/tcsel_if.sv ----
// Carrier between the control logic and the prescaler
`timescale 1ns/1ps
`default_nettype none
interface tcsel_if;
  logic [1:0] shared_prescale_field;
  logic ext_edge;
  logic presc_tick;
  modport ctrl (output shared_prescale_field, output ext_edge, input presc_tick);
  modport presc (input shared_prescale_field, input ext_edge, output presc_tick);
endinterface
`default_nettype wire

// ---- rtl/tcsel_prescaler.sv ----
// Shared prescaler producing one-cycle ticks at the selected division
`timescale 1ns/1ps
`default_nettype none
module tcsel_prescaler
  import tcsel_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  tcsel_if.presc pif
);
  function automatic logic [TCSEL_CNT_W-1:0] div_terminal(input logic [1:0] f);
    logic [TCSEL_CNT_W-1:0] t;
    t = '0;
    case (f)
      TCSEL_PRE_SYS12: t = TCSEL_CNT_W'(TCSEL_DIV_SYS12 - 1);
      TCSEL_PRE_SYS4: t = TCSEL_CNT_W'(TCSEL_DIV_SYS4 - 1);
      TCSEL_PRE_SYS48: t = TCSEL_CNT_W'(TCSEL_DIV_SYS48 - 1);
      default: t = TCSEL_CNT_W'(TCSEL_DIV_EXT8 - 1);
    endcase
    return t;
  endfunction

  logic [TCSEL_CNT_W-1:0] cnt_reg;
  logic [1:0] field_last_reg;
  // Cycles since the last tick, kept apart from the divider count
  logic [TCSEL_CNT_W-1:0] gap_reg;
  wire logic field_changed = (pif.shared_prescale_field != field_last_reg);
  // External mode counts synchronised oscillator edges, others every clock
  wire logic advance = (pif.shared_prescale_field == TCSEL_PRE_EXT8) ? pif.ext_edge : 1'b1;
  wire logic at_term = (cnt_reg == div_terminal(pif.shared_prescale_field));
  wire logic [TCSEL_CNT_W-1:0] cnt_next = field_changed ? '0 :
    (!advance ? cnt_reg : (at_term ? '0 : cnt_reg + TCSEL_CNT_W'(1)));

  assign pif.presc_tick = advance && at_term && !field_changed;

  wire logic gap_full = (gap_reg == '1);
  wire logic [TCSEL_CNT_W-1:0] gap_next = (pif.presc_tick || field_changed) ? '0 :
    (gap_full ? gap_reg : gap_reg + TCSEL_CNT_W'(1));

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      field_last_reg <= TCSEL_PRE_SYS12;
      gap_reg <= '0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      field_last_reg <= pif.shared_prescale_field;
      gap_reg <= gap_next;
    end
  end

  sequence s_hold12;
    (pif.shared_prescale_field == TCSEL_PRE_SYS12) && !field_changed;
  endsequence
  sequence s_hold4;
    (pif.shared_prescale_field == TCSEL_PRE_SYS4)[*4];
  endsequence

  div12_period_a: assert property (@(posedge clock) disable iff (!rst_n)
    s_hold12 |-> (pif.presc_tick == (gap_reg == TCSEL_CNT_W'(TCSEL_DIV_SYS12 - 1))))
    else $error("divide by 12 tick spacing wrong");
  div4_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
    (pif.presc_tick && pif.shared_prescale_field == TCSEL_PRE_SYS4) ##1 s_hold4
    |-> pif.presc_tick && $past(!pif.presc_tick, 1) && $past(!pif.presc_tick, 3))
    else $error("divide by 4 tick spacing wrong");
  ext_edge_only_a: assert property (@(posedge clock) disable iff (!rst_n)
    (pif.shared_prescale_field == TCSEL_PRE_EXT8 && pif.presc_tick) |-> pif.ext_edge)
    else $error("external prescale ticked without an oscillator edge");
endmodule
`default_nettype wire

// ---- rtl/tcsel_top.sv ----
// Timer 0/1 clock select register, input synchronisers and tick outputs
`timescale 1ns/1ps
`default_nettype none
module tcsel_top
  import tcsel_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr_en,
  input wire logic sfr_rd_en,
  input wire logic [7:0] sfr_wdata,
  input wire logic timer0_counter_mode,
  input wire logic timer1_counter_mode,
  input wire logic ext_osc_clk,
  input wire logic timer0_pin,
  input wire logic timer1_pin,
  output logic [7:0] sfr_rdata,
  output logic timer0_tick,
  output logic timer1_tick,
  output logic [1:0] active_prescale_field
);
  tcsel_if pif ();

  logic [7:0] timer_clock_control_reg;
  logic [7:0] sfr_rdata_reg;
  logic timer0_tick_reg;
  logic timer1_tick_reg;

  // Three-stage synchronisers for the pins and external oscillator
  logic [TCSEL_SYNC_STAGES-1:0] osc_sync_reg;
  logic [TCSEL_SYNC_STAGES-1:0] t0_sync_reg;
  logic [TCSEL_SYNC_STAGES-1:0] t1_sync_reg;
  logic osc_level_reg;
  logic t0_level_reg;
  logic t1_level_reg;

  wire logic addr_hit = (sfr_addr == TCSEL_CLK_CTRL_ADDR);
  wire logic reg_write = sfr_wr_en && addr_hit;
  wire logic reg_read = sfr_rd_en && addr_hit;
  wire logic [7:0] ctrl_next = reg_write ? (sfr_wdata & TCSEL_CLK_CTRL_WMASK)
                                         : timer_clock_control_reg;
  wire logic [7:0] rdata_next = reg_read ? (timer_clock_control_reg & TCSEL_CLK_CTRL_WMASK)
                                         : 8'h00;

  wire logic timer0_sysclk_select = timer_clock_control_reg[TCSEL_T0_SEL_BIT];
  wire logic timer1_sysclk_select = timer_clock_control_reg[TCSEL_T1_SEL_BIT];
  wire logic [1:0] shared_prescale_field =
    timer_clock_control_reg[TCSEL_FIELD_LSB +: TCSEL_FIELD_W];

  // A level change counts once the second and third stages agree
  wire logic osc_agree = (osc_sync_reg[1] == osc_sync_reg[2]);
  wire logic t0_agree = (t0_sync_reg[1] == t0_sync_reg[2]);
  wire logic t1_agree = (t1_sync_reg[1] == t1_sync_reg[2]);
  wire logic osc_level_next = osc_agree ? osc_sync_reg[2] : osc_level_reg;
  wire logic t0_level_next = t0_agree ? t0_sync_reg[2] : t0_level_reg;
  wire logic t1_level_next = t1_agree ? t1_sync_reg[2] : t1_level_reg;
  wire logic osc_rise = osc_level_next && !osc_level_reg;
  wire logic t0_fall = !t0_level_next && t0_level_reg;
  wire logic t1_fall = !t1_level_next && t1_level_reg;

  assign pif.shared_prescale_field = shared_prescale_field;
  assign pif.ext_edge = osc_rise;

  tcsel_prescaler u_prescaler (
    .clock(clock),
    .rst_n(rst_n),
    .pif(pif)
  );

  // Timer mode picks the system clock or the shared tick; counter mode ignores it
  wire logic t0_timer_src = timer0_sysclk_select ? 1'b1 : pif.presc_tick;
  wire logic t1_timer_src = timer1_sysclk_select ? 1'b1 : pif.presc_tick;
  wire logic timer0_tick_next = timer0_counter_mode ? t0_fall : t0_timer_src;
  wire logic timer1_tick_next = timer1_counter_mode ? t1_fall : t1_timer_src;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_clock_control_reg <= TCSEL_CLK_CTRL_RESET;
      sfr_rdata_reg <= 8'h00;
    end
    else
    begin
      timer_clock_control_reg <= ctrl_next;
      sfr_rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_sync_reg <= '0;
      t0_sync_reg <= '1;
      t1_sync_reg <= '1;
    end
    else
    begin
      osc_sync_reg <= {osc_sync_reg[TCSEL_SYNC_STAGES-2:0], ext_osc_clk};
      t0_sync_reg <= {t0_sync_reg[TCSEL_SYNC_STAGES-2:0], timer0_pin};
      t1_sync_reg <= {t1_sync_reg[TCSEL_SYNC_STAGES-2:0], timer1_pin};
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_level_reg <= 1'b0;
      t0_level_reg <= 1'b1;
      t1_level_reg <= 1'b1;
    end
    else
    begin
      osc_level_reg <= osc_level_next;
      t0_level_reg <= t0_level_next;
      t1_level_reg <= t1_level_next;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer0_tick_reg <= 1'b0;
      timer1_tick_reg <= 1'b0;
    end
    else
    begin
      timer0_tick_reg <= timer0_tick_next;
      timer1_tick_reg <= timer1_tick_next;
    end
  end

  assign sfr_rdata = sfr_rdata_reg;
  assign timer0_tick = timer0_tick_reg;
  assign timer1_tick = timer1_tick_reg;
  assign active_prescale_field = timer_clock_control_reg[TCSEL_FIELD_LSB +: TCSEL_FIELD_W];

  // Steps of a timer-mode selection
  sequence s_t0_timer_sys;
    !timer0_counter_mode && timer0_sysclk_select;
  endsequence
  sequence s_t0_timer_presc;
    !timer0_counter_mode && !timer0_sysclk_select;
  endsequence
  sequence s_t1_timer_sys;
    !timer1_counter_mode && timer1_sysclk_select;
  endsequence

  t0_counter_pin_a: assert property (@(posedge clock) disable iff (!rst_n)
    timer0_counter_mode |=> (timer0_tick == $past(t0_fall)))
    else $error("timer 0 counter mode did not follow its pin");
  t0_sel_ignored_a: assert property (@(posedge clock) disable iff (!rst_n)
    (timer0_counter_mode && !t0_fall) |=> !timer0_tick)
    else $error("timer 0 ticked in counter mode without a pin edge");
  t0_presc_tick_a: assert property (@(posedge clock) disable iff (!rst_n)
    s_t0_timer_presc |=> (timer0_tick == $past(pif.presc_tick)))
    else $error("timer 0 prescaled tick mismatch");
  t0_sysclk_run_a: assert property (@(posedge clock) disable iff (!rst_n)
    s_t0_timer_sys [*3] |=> timer0_tick && $past(timer0_tick))
    else $error("timer 0 missed a system clock tick");
  t1_sysclk_run_a: assert property (@(posedge clock) disable iff (!rst_n)
    s_t1_timer_sys |=> timer1_tick)
    else $error("timer 1 missed a system clock tick");
  t1_presc_tick_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!timer1_counter_mode && !timer1_sysclk_select) |=>
    (timer1_tick == $past(pif.presc_tick)))
    else $error("timer 1 prescaled tick mismatch");
  t1_counter_pin_a: assert property (@(posedge clock) disable iff (!rst_n)
    timer1_counter_mode |=> (timer1_tick == $past(t1_fall)))
    else $error("timer 1 counter mode did not follow its pin");
  ctrl_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    reg_write |=> ##1 (sfr_rdata[2] == 1'b0) && (sfr_rdata[7:5] == 3'h0))
    else $error("unused control bits did not read zero");
  field_tracks_a: assert property (@(posedge clock) disable iff (!rst_n)
    reg_write |=> (active_prescale_field == $past(sfr_wdata[1:0])))
    else $error("prescale field did not take the written value");

  // Steps of a register read
  sequence s_ctrl_read;
    reg_read;
  endsequence
  sequence s_no_read;
    !reg_read;
  endsequence

  read_hit_a: assert property (@(posedge clock) disable iff (!rst_n)
    s_ctrl_read |=> (sfr_rdata == $past(timer_clock_control_reg)))
    else $error("control register read returned the wrong value");
  read_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
    s_no_read |=> (sfr_rdata == 8'h00))
    else $error("read data not zero without a read");
  ctrl_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    !reg_write |=> $stable(timer_clock_control_reg))
    else $error("control register changed without a write");
  ctrl_spare_a: assert property (@(posedge clock) disable iff (!rst_n)
    (timer_clock_control_reg & ~TCSEL_CLK_CTRL_WMASK) == 8'h00)
    else $error("unused control bits were set");
  t0_sel_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
    reg_write |=> (timer0_sysclk_select == $past(sfr_wdata[TCSEL_T0_SEL_BIT])))
    else $error("timer 0 select bit did not take the written value");
  t1_sel_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
    reg_write |=> (timer1_sysclk_select == $past(sfr_wdata[TCSEL_T1_SEL_BIT])))
    else $error("timer 1 select bit did not take the written value");
  t1_sel_ignored_a: assert property (@(posedge clock) disable iff (!rst_n)
    (timer1_counter_mode && !t1_fall) |=> !timer1_tick)
    else $error("timer 1 ticked in counter mode without a pin edge");
  t1_sysclk_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    s_t1_timer_sys [*3] |=> timer1_tick && $past(timer1_tick))
    else $error("timer 1 dropped a system clock tick");
  ext_edge_gap_a: assert property (@(posedge clock) disable iff (!rst_n)
    pif.ext_edge |=> !pif.ext_edge)
    else $error("oscillator edges seen on two cycles in a row");
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the timer clock select and prescaler block
`timescale 1ns/1ps
`default_nettype none
module tb
  import tcsel_pkg::*;
;
  logic clock;
  logic rst_n;
  logic [7:0] sfr_addr;
  logic sfr_wr_en;
  logic sfr_rd_en;
  logic [7:0] sfr_wdata;
  logic timer0_counter_mode;
  logic timer1_counter_mode;
  logic ext_osc_clk;
  logic timer0_pin;
  logic timer1_pin;
  logic [7:0] sfr_rdata;
  logic timer0_tick;
  logic timer1_tick;
  logic [1:0] active_prescale_field;
  int err_total;
  int n_compared;
  int p0;
  int p1;
  logic [1:0] codes [3];
  int divs [3];

  tcsel_top uut (.clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
    .sfr_rd_en(sfr_rd_en), .sfr_wdata(sfr_wdata), .timer0_counter_mode(timer0_counter_mode),
    .timer1_counter_mode(timer1_counter_mode), .ext_osc_clk(ext_osc_clk),
    .timer0_pin(timer0_pin), .timer1_pin(timer1_pin), .sfr_rdata(sfr_rdata),
    .timer0_tick(timer0_tick), .timer1_tick(timer1_tick),
    .active_prescale_field(active_prescale_field));

  always #12.5 clock = ~clock;
  // Oscillator offset from the system clock so synchronisation never races
  initial
  begin
    ext_osc_clk = 1'b0;
    #7;
    forever #100 ext_osc_clk = ~ext_osc_clk;
  end

  task automatic complete_run();
    if (err_total == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr_en <= 1'b1;
    @(posedge clock);
    sfr_wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    sfr_addr <= a;
    sfr_rd_en <= 1'b1;
    @(posedge clock);
    sfr_rd_en <= 1'b0;
    #1;
    check("sfr_rdata", sfr_rdata, exp);
  endtask

  function automatic logic pick(input bit w);
    return w ? timer1_tick : timer0_tick;
  endfunction

  // Cycles between two successive ticks of one timer
  task automatic measure(input bit w, output int p);
    int k;
    k = 0;
    // Skip two cycles; the first may still show a tick of the old setting
    repeat (2) @(posedge clock);
    @(negedge clock);
    while (pick(w) !== 1'b1 && k < 300)
    begin
      @(negedge clock);
      k++;
    end
    @(negedge clock);
    p = 1;
    while (pick(w) !== 1'b1 && p < 300)
    begin
      @(negedge clock);
      p++;
    end
  endtask

  task automatic count_ticks(input int n, output int c0, output int c1);
    c0 = 0;
    c1 = 0;
    repeat (n)
    begin
      @(negedge clock);
      c0 += (timer0_tick === 1'b1);
      c1 += (timer1_tick === 1'b1);
    end
  endtask

  initial
  begin
    #500us;
    err_total++;
    complete_run();
  end

  initial
  begin
    clock = 1'b0;
    rst_n = 1'b0;
    sfr_addr = 8'h00;
    sfr_wr_en = 1'b0;
    sfr_rd_en = 1'b0;
    sfr_wdata = 8'h00;
    timer0_counter_mode = 1'b0;
    timer1_counter_mode = 1'b0;
    timer0_pin = 1'b1;
    timer1_pin = 1'b1;
    err_total = 0;
    n_compared = 0;
    codes = '{TCSEL_PRE_SYS12, TCSEL_PRE_SYS4, TCSEL_PRE_SYS48};
    divs = '{TCSEL_DIV_SYS12, TCSEL_DIV_SYS4, TCSEL_DIV_SYS48};
    repeat (12) @(posedge clock);
    check("tick0 in reset", {7'h00, timer0_tick}, 8'h00);
    rst_n <= 1'b1;
    rd(8'h8E, 8'h00);
    wr(8'h8E, 8'hFF);
    rd(8'h8E, 8'h1B);
    check("field", {6'h00, active_prescale_field}, 8'h03);
    wr(8'h8F, 8'h00);
    rd(8'h8E, 8'h1B);
    rd(8'h8F, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h8E, {6'h00, codes[i]});
      measure(1'b0, p0);
      measure(1'b1, p1);
      check("t0 period", 8'(p0), 8'(divs[i]));
      check("t1 period", 8'(p1), 8'(divs[i]));
      check("field", {6'h00, active_prescale_field}, {6'h00, codes[i]});
    end
    wr(8'h8E, 8'h09);
    repeat (3) @(posedge clock);
    count_ticks(16, p0, p1);
    check("t0 sysclk", 8'(p0), 8'h10);
    check("t1 prescaled", 8'(p1), 8'h04);
    wr(8'h8E, 8'h11);
    repeat (3) @(posedge clock);
    count_ticks(16, p0, p1);
    check("t0 prescaled", 8'(p0), 8'h04);
    check("t1 sysclk", 8'(p1), 8'h10);
    foreach (codes[i])
    begin
      wr(8'h8E, (i == 0) ? 8'h19 : 8'h01);
      timer0_counter_mode <= 1'b1;
      timer1_counter_mode <= 1'b1;
      repeat (8) @(posedge clock);
      count_ticks(20, p0, p1);
      check("t0 cnt idle", 8'(p0), 8'h00);
      check("t1 cnt idle", 8'(p1), 8'h00);
      @(posedge clock);
      timer0_pin <= 1'b0;
      count_ticks(10, p0, p1);
      check("t0 pin fall", 8'(p0), 8'h01);
      check("t1 no fall", 8'(p1), 8'h00);
      @(posedge clock);
      timer1_pin <= 1'b0;
      count_ticks(10, p0, p1);
      check("t0 no fall", 8'(p0), 8'h00);
      check("t1 pin fall", 8'(p1), 8'h01);
      @(posedge clock);
      timer0_pin <= 1'b1;
      timer1_pin <= 1'b1;
      timer0_counter_mode <= 1'b0;
      timer1_counter_mode <= 1'b0;
    end
    wr(8'h8E, 8'h03);
    measure(1'b0, p0);
    measure(1'b1, p1);
    check("t0 ext", 8'(p0), 8'(TCSEL_DIV_EXT8 * 8));
    check("t1 ext", 8'(p1), 8'(TCSEL_DIV_EXT8 * 8));
    complete_run();
  end
endmodule
`default_nettype wire
